// ---- shared/fcs_pkg.sv ----
// Constants and types shared by the flash command sequencer host controller
// ============================================================
package fcs_pkg;
  // ============================================================
  // Command words and addresses
  localparam logic [10:0] FCS_ADDR_UNLOCK1 = 11'h555;
  localparam logic [10:0] FCS_ADDR_UNLOCK2 = 11'h2AA;
  localparam logic [7:0] FCS_DAT_UNLOCK1 = 8'hAA;
  localparam logic [7:0] FCS_DAT_UNLOCK2 = 8'h55;
  localparam logic [7:0] FCS_DAT_PROGRAM = 8'hA0;
  localparam logic [7:0] FCS_DAT_ERASE_SETUP = 8'h80;
  localparam logic [7:0] FCS_DAT_SECTOR = 8'h30;
  localparam logic [7:0] FCS_DAT_BLOCK = 8'h50;
  localparam logic [7:0] FCS_DAT_CHIP = 8'h10;
  localparam logic [7:0] FCS_DAT_SUSPEND = 8'hB0;
  localparam logic [7:0] FCS_DAT_RESUME = 8'h30;
  localparam logic [7:0] FCS_DAT_SEC_QUERY = 8'h88;
  localparam logic [7:0] FCS_DAT_UID_PROG = 8'hA5;
  localparam logic [7:0] FCS_DAT_UID_LOCK = 8'h85;
  localparam logic [15:0] FCS_DAT_LOCK_WORD = 16'h0000;
  localparam logic [7:0] FCS_DAT_ID_ENTRY = 8'h90;
  localparam logic [7:0] FCS_DAT_QUERY_ENTRY = 8'h98;
  localparam logic [7:0] FCS_DAT_EXIT = 8'hF0;
  localparam logic [19:0] FCS_UID_FIRST = 20'h00010;
  localparam logic [19:0] FCS_UID_LAST = 20'h00017;
  localparam logic [19:0] FCS_LOCK_STATUS_ADDR = 20'h000FF;
  localparam int FCS_LOCK_BIT = 3;
  // ============================================================
  // Bus timing (cycles of the 50 MHz clock)
  localparam int FCS_CLK_NS = 20;
  localparam int FCS_SETUP_NS = 40;
  localparam int FCS_PULSE_NS = 60;
  localparam int FCS_READ_NS = 80;
  localparam int FCS_SETUP_CYC = (FCS_SETUP_NS + FCS_CLK_NS - 1) / FCS_CLK_NS;
  localparam int FCS_PULSE_CYC = (FCS_PULSE_NS + FCS_CLK_NS - 1) / FCS_CLK_NS;
  localparam int FCS_READ_CYC = (FCS_READ_NS + FCS_CLK_NS - 1) / FCS_CLK_NS;
  localparam int FCS_SEQ_MAX = 6;
  // ============================================================
  // Commands accepted on the user port
  typedef enum logic [3:0] {
    FCS_CMD_PROGRAM = 4'h0,
    FCS_CMD_SECTOR_ERASE = 4'h1,
    FCS_CMD_BLOCK_ERASE = 4'h2,
    FCS_CMD_CHIP_ERASE = 4'h3,
    FCS_CMD_SUSPEND = 4'h4,
    FCS_CMD_RESUME = 4'h5,
    FCS_CMD_SEC_QUERY = 4'h6,
    FCS_CMD_UID_PROGRAM = 4'h7,
    FCS_CMD_UID_LOCK = 4'h8,
    FCS_CMD_ID_ENTRY = 4'h9,
    FCS_CMD_QUERY_ENTRY = 4'hA,
    FCS_CMD_EXIT_LONG = 4'hB,
    FCS_CMD_EXIT_SHORT = 4'hC,
    FCS_CMD_READ = 4'hD
  } fcs_cmd_type;
  typedef enum logic [2:0] {
    FCS_ST_IDLE = 3'b000,
    FCS_ST_SETUP = 3'b001,
    FCS_ST_PULSE = 3'b011,
    FCS_ST_HOLD = 3'b010,
    FCS_ST_READ = 3'b110
  } fcs_state_type;
endpackage

// ---- verilog/fcs_seq_rom.sv ----
// Write-sequence table: address and data of each bus cycle of a command
`timescale 1ns/10ps
module fcs_seq_rom
  import fcs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire fcs_cmd_type cmd,
  input wire logic [2:0] step,
  input wire logic [19:0] user_addr,
  input wire logic [15:0] user_data,
  output logic [2:0] seq_len,
  output logic [19:0] seq_addr_q,
  output logic [15:0] seq_data_q
);
  typedef struct packed {
    logic [19:0] addr;
    logic [15:0] data;
  } fcs_rom_type;
  fcs_rom_type rom_q;
  fcs_rom_type rom_d;
  logic [7:0] dat;
  logic [10:0] adr;
  logic last;

  assign seq_addr_q = rom_q.addr;
  assign seq_data_q = rom_q.data;

  // ============================================================
  // Length of each command in bus cycles (write cycles, or the one read cycle of FCS_CMD_READ)
  always_comb begin
    case (cmd)
      FCS_CMD_PROGRAM, FCS_CMD_UID_PROGRAM, FCS_CMD_UID_LOCK: seq_len = 3'd4;
      FCS_CMD_SECTOR_ERASE, FCS_CMD_BLOCK_ERASE, FCS_CMD_CHIP_ERASE: seq_len = 3'd6;
      FCS_CMD_SUSPEND, FCS_CMD_RESUME, FCS_CMD_EXIT_SHORT, FCS_CMD_READ: seq_len = 3'd1;
      default: seq_len = 3'd3;
    endcase
  end

  // ============================================================
  // Per-step address and data
  always_comb begin
    last = (step == seq_len - 3'd1);
    adr = (step == 3'd1 || step == 3'd4) ? FCS_ADDR_UNLOCK2 : FCS_ADDR_UNLOCK1;
    dat = (step == 3'd1 || step == 3'd4) ? FCS_DAT_UNLOCK2 : FCS_DAT_UNLOCK1;
    rom_d.addr = {9'h000, adr};
    rom_d.data = {8'h00, dat};
    if (step == 3'd2) begin
      case (cmd)
        FCS_CMD_PROGRAM: rom_d.data = {8'h00, FCS_DAT_PROGRAM};
        FCS_CMD_SECTOR_ERASE, FCS_CMD_BLOCK_ERASE, FCS_CMD_CHIP_ERASE:
          rom_d.data = {8'h00, FCS_DAT_ERASE_SETUP};
        FCS_CMD_SEC_QUERY: rom_d.data = {8'h00, FCS_DAT_SEC_QUERY};
        FCS_CMD_UID_PROGRAM: rom_d.data = {8'h00, FCS_DAT_UID_PROG};
        FCS_CMD_UID_LOCK: rom_d.data = {8'h00, FCS_DAT_UID_LOCK};
        FCS_CMD_ID_ENTRY: rom_d = '{{2'b00, user_addr[17:11], adr}, {8'h00, FCS_DAT_ID_ENTRY}};
        FCS_CMD_QUERY_ENTRY:
          rom_d = '{{2'b00, user_addr[17:11], adr}, {8'h00, FCS_DAT_QUERY_ENTRY}};
        FCS_CMD_EXIT_LONG: rom_d.data = {8'h00, FCS_DAT_EXIT};
        default: rom_d.data = {8'h00, dat};
      endcase
    end
    if (last) begin
      case (cmd)
        FCS_CMD_PROGRAM, FCS_CMD_READ: rom_d = '{user_addr, user_data};
        // target forced into user ident window
        FCS_CMD_UID_PROGRAM: rom_d = '{{FCS_UID_FIRST[19:3], user_addr[2:0]}, user_data};
        FCS_CMD_UID_LOCK: rom_d = '{user_addr, FCS_DAT_LOCK_WORD};
        FCS_CMD_SECTOR_ERASE: rom_d = '{{user_addr[19:11], 11'h000}, {8'h00, FCS_DAT_SECTOR}};
        // block by A19..A15, chip at 555
        FCS_CMD_BLOCK_ERASE: rom_d = '{{user_addr[19:15], 15'h0000}, {8'h00, FCS_DAT_BLOCK}};
        FCS_CMD_CHIP_ERASE: rom_d.data = {8'h00, FCS_DAT_CHIP};
        FCS_CMD_SUSPEND: rom_d = '{user_addr, {8'h00, FCS_DAT_SUSPEND}};
        FCS_CMD_RESUME: rom_d = '{user_addr, {8'h00, FCS_DAT_RESUME}};
        FCS_CMD_EXIT_SHORT: rom_d = '{user_addr, {8'h00, FCS_DAT_EXIT}};
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rom_q <= '0;
    end else begin
      rom_q <= rom_d;
    end
  end
endmodule

// ---- verilog/fcs_host.sv ----
// Host controller driving the flash command sequences on the parallel pins
`timescale 1ns/10ps
module fcs_host
  import fcs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire fcs_cmd_type cmd,
  input wire logic [19:0] cmd_addr,
  input wire logic [15:0] cmd_data,
  input wire logic byte_mode,
  output logic done,
  output logic refused,
  output logic [15:0] rd_data,
  output logic flash_enable_n,
  output logic psram_enable_low_n,
  output logic psram_enable_high,
  output logic oe_n,
  output logic we_n,
  output logic byte_word_select,
  output logic [19:0] addr,
  output logic addr_m1,
  input wire logic [15:0] dq_in,
  output logic [15:0] dq_out,
  output logic dq_oe
);
  // ============================================================
  // State
  typedef struct packed {
    fcs_state_type st;
    fcs_cmd_type cmd;
    logic [19:0] uaddr;
    logic [15:0] udata;
    logic [2:0] step;
    logic [3:0] cnt;
    logic done;
    logic refused;
    logic [15:0] rd;
    logic bytem;
    logic fe_n;
    logic oe_n;
    logic we_n;
    logic dq_oe;
    logic [15:0] s1;
    logic [15:0] s2;
    logic [15:0] s3;
  } fcs_host_type;
  fcs_host_type r_q;
  fcs_host_type r_d;
  logic [2:0] seq_len;
  logic [19:0] seq_addr_q;
  logic [15:0] seq_data_q;

  // Lock-out needs word-wide mode; refuse it in byte mode
  // Codes outside the table are refused too, or they would emit a stray unlock prefix
  function automatic logic illegal(input fcs_cmd_type c, input logic b);
    case (c)
      FCS_CMD_UID_LOCK: illegal = b;
      FCS_CMD_PROGRAM, FCS_CMD_SECTOR_ERASE, FCS_CMD_BLOCK_ERASE, FCS_CMD_CHIP_ERASE,
      FCS_CMD_SUSPEND, FCS_CMD_RESUME, FCS_CMD_SEC_QUERY, FCS_CMD_UID_PROGRAM,
      FCS_CMD_ID_ENTRY, FCS_CMD_QUERY_ENTRY, FCS_CMD_EXIT_LONG, FCS_CMD_EXIT_SHORT,
      FCS_CMD_READ: illegal = 1'b0;
      default: illegal = 1'b1;
    endcase
  endfunction

  // ============================================================
  // Command table
  fcs_seq_rom u_rom (
    .clk(clk),
    .rst_b(rst_b),
    .cmd(r_q.cmd),
    .step(r_q.step),
    .user_addr(r_q.uaddr),
    .user_data(r_q.udata),
    .seq_len(seq_len),
    .seq_addr_q(seq_addr_q),
    .seq_data_q(seq_data_q)
  );

  // ============================================================
  // Pins
  // pseudo-SRAM held disabled at all times
  assign psram_enable_low_n = 1'b1;
  assign psram_enable_high = 1'b0;
  assign flash_enable_n = r_q.fe_n;
  assign oe_n = r_q.oe_n;
  assign we_n = r_q.we_n;
  assign dq_oe = r_q.dq_oe;
  assign byte_word_select = ~r_q.bytem;
  // byte mode: extra address line low, upper data lanes low
  assign addr_m1 = 1'b0;
  // word mode: table address and data leave unchanged
  // Ignored lines are driven low so they stay at valid levels; address lines always, data 15..8 only while dq_oe is high
  always_comb begin
    addr = seq_addr_q;
    dq_out = seq_data_q;
    // byte mode clears address 19..12 and data 15..8
    if (r_q.bytem) begin
      addr = {8'h00, seq_addr_q[11:0]};
      dq_out = {8'h00, seq_data_q[7:0]};
    end
  end

  // ============================================================
  // Handshake
  // Ready is combinational so a new command is taken the cycle done is seen
  assign cmd_ready = (r_q.st == FCS_ST_IDLE);
  assign done = r_q.done;
  assign refused = r_q.refused;
  assign rd_data = r_q.rd;

  // ============================================================
  // Sequencer
  always_comb begin
    r_d = r_q;
    r_d.done = 1'b0;
    r_d.refused = 1'b0;
    // Data bus sync; the third stage only feeds the agreement test
    r_d.s1 = dq_in;
    r_d.s2 = r_q.s1;
    r_d.s3 = r_q.s2;
    case (r_q.st)
      FCS_ST_IDLE: begin
        if (cmd_valid) begin
          if (illegal(cmd, byte_mode)) begin
            r_d.refused = 1'b1;
          end else begin
            r_d.cmd = cmd;
            r_d.uaddr = cmd_addr;
            r_d.udata = cmd_data;
            r_d.bytem = byte_mode;
            r_d.step = 3'd0;
            r_d.cnt = 4'(FCS_SETUP_CYC);
            r_d.st = FCS_ST_SETUP;
          end
        end
      end
      FCS_ST_SETUP: begin
        r_d.fe_n = 1'b0;
        r_d.cnt = r_q.cnt - 4'd1;
        if (r_q.cnt == 4'd1) begin
          if (r_q.cmd == FCS_CMD_READ) begin
            r_d.oe_n = 1'b0;
            r_d.cnt = 4'(FCS_READ_CYC);
            r_d.st = FCS_ST_READ;
          end else begin
            r_d.we_n = 1'b0;
            r_d.dq_oe = 1'b1;
            r_d.cnt = 4'(FCS_PULSE_CYC);
            r_d.st = FCS_ST_PULSE;
          end
        end
      end
      FCS_ST_PULSE: begin
        r_d.cnt = r_q.cnt - 4'd1;
        if (r_q.cnt == 4'd1) begin
          r_d.we_n = 1'b1;
          r_d.cnt = 4'd1;
          r_d.st = FCS_ST_HOLD;
        end
      end
      FCS_ST_HOLD: begin
        r_d.dq_oe = 1'b0;
        r_d.fe_n = 1'b1;
        // every cycle of a sequence is issued before done
        if (r_q.step == seq_len - 3'd1) begin
          r_d.done = 1'b1;
          r_d.st = FCS_ST_IDLE;
        end else begin
          r_d.step = r_q.step + 3'd1;
          r_d.cnt = 4'(FCS_SETUP_CYC);
          r_d.st = FCS_ST_SETUP;
        end
      end
      FCS_ST_READ: begin
        r_d.cnt = r_q.cnt - 4'd1;
        if (r_q.cnt == 4'd1) begin
          // Bus settled for the full access; stages two and three agree
          if (r_q.s2 == r_q.s3) begin
            r_d.rd = r_q.bytem ? {8'h00, r_q.s2[7:0]} : r_q.s2;
            r_d.oe_n = 1'b1;
            r_d.fe_n = 1'b1;
            r_d.done = 1'b1;
            r_d.st = FCS_ST_IDLE;
          end else begin
            r_d.cnt = 4'd1;
          end
        end
      end
      default: r_d.st = FCS_ST_IDLE;
    endcase
  end

  // ============================================================
  // Register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      // Bus parked: every enable and strobe inactive, host not driving data
      r_q <= '{
        st: FCS_ST_IDLE,
        cmd: FCS_CMD_READ,
        uaddr: 20'h00000,
        udata: 16'h0000,
        step: 3'h0,
        cnt: 4'h0,
        done: 1'h0,
        refused: 1'h0,
        rd: 16'h0000,
        bytem: 1'h0,
        fe_n: 1'h1,
        oe_n: 1'h1,
        we_n: 1'h1,
        dq_oe: 1'h0,
        s1: 16'h0000,
        s2: 16'h0000,
        s3: 16'h0000
      };
    end else begin
      r_q <= r_d;
    end
  end
endmodule

// ---- verif/fcs_host_assertions.sv ----
// Checker of the host pin sequencing
`timescale 1ns/10ps
module fcs_host_assertions
  import fcs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire fcs_cmd_type cmd,
  input wire logic byte_mode,
  input wire logic done,
  input wire logic refused,
  input wire logic flash_enable_n,
  input wire logic psram_enable_low_n,
  input wire logic psram_enable_high,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic byte_word_select,
  input wire logic [19:0] addr,
  input wire logic addr_m1,
  input wire logic dq_oe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  wire take = cmd_valid && cmd_ready;
  // ============================================================
  // Sequences and properties
  sequence s_pulse;
    !we_n [*3] ##1 we_n;
  endsequence
  sequence s_take(fcs_cmd_type c);
    take && cmd == c;
  endsequence
  property p_pulse;
    $fell(we_n) |-> s_pulse;
  endproperty
  property p_prog;
    s_take(FCS_CMD_PROGRAM) |-> ##25 done;
  endproperty
  property p_sector;
    s_take(FCS_CMD_SECTOR_ERASE) |-> ##37 done;
  endproperty
  property p_single;
    take && cmd inside {FCS_CMD_SUSPEND, FCS_CMD_RESUME} |-> ##7 done;
  endproperty
  property p_refuse;
    s_take(FCS_CMD_UID_LOCK) ##0 byte_mode |=> refused && we_n;
  endproperty
  property p_psram;
    psram_enable_low_n && !psram_enable_high;
  endproperty
  property p_write;
    !we_n |-> !flash_enable_n && dq_oe && oe_n;
  endproperty
  property p_byte;
    !byte_word_select && !we_n |-> addr[19:12] == 8'h00 && !addr_m1;
  endproperty
  property p_hold;
    !we_n |-> $stable(addr);
  endproperty
  a_pulse: assert property (p_pulse) else $error("write pulse length");
  a_prog: assert property (p_prog) else $error("program length");
  a_sector: assert property (p_sector) else $error("sector erase length");
  a_single: assert property (p_single) else $error("single write length");
  a_refuse: assert property (p_refuse) else $error("byte lock-out taken");
  a_psram: assert property (p_psram) else $error("psram enabled");
  a_write: assert property (p_write) else $error("write without enable");
  a_byte: assert property (p_byte) else $error("byte address high bits");
  a_hold: assert property (p_hold) else $error("address moved in pulse");
endmodule
bind fcs_host fcs_host_assertions u_chk(.clk, .rst_b, .cmd_valid, .cmd_ready, .cmd,
  .byte_mode, .done, .refused, .flash_enable_n, .psram_enable_low_n, .psram_enable_high,
  .oe_n, .we_n, .byte_word_select, .addr, .addr_m1, .dq_oe);

// ---- verif/fcs_dev_model.sv ----
// Behavioural flash device answering the host pins
`timescale 1ns/10ps
module fcs_dev_model
  import fcs_pkg::*;
#(
  // Identifier values are arbitrary
  parameter logic [15:0] MAKER_ID = 16'h00C3,
  parameter logic [15:0] PART_ID = 16'h5A21
)(
  input wire logic clk,
  input wire logic flash_enable_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [19:0] addr,
  input wire logic [15:0] dq_out,
  input wire logic dq_oe,
  output logic [15:0] dq_in
);
  logic [19:0] la [64];
  logic [15:0] ld [64];
  logic [15:0] uid [8];
  logic [15:0] rv;
  logic [15:0] last = 16'h0;
  logic [7:0] op;
  logic lk = 1'b0;
  int n = 0;
  int st = 0;
  int mode = 0;
  initial foreach (uid[i]) uid[i] = 16'hFFFF;
  // ============================================================
  // Command decode, low byte and address 10..0 only
  // decode
  always @(posedge we_n) if (!flash_enable_n && dq_oe) begin
    la[n] = addr;
    ld[n] = dq_out;
    n++;
    if (st == 3) begin
      if (op == 8'hA5 && !lk) uid[addr[2:0]] = uid[addr[2:0]] & dq_out;
      if (op == 8'h85) lk = 1'b1;
      st = 0;
    end else if (dq_out[7:0] == 8'hF0) begin
      mode = 0;
      st = 0;
    end else if (addr[10:0] == 11'h555 && dq_out[7:0] == 8'hAA) st = 1;
    else if (st == 1 && addr[10:0] == 11'h2AA && dq_out[7:0] == 8'h55) st = 2;
    else if (st == 2) begin
      op = dq_out[7:0];
      st = (op == 8'hA5 || op == 8'h85) ? 3 : 0;
      if (op == 8'h90) mode = 1;
      if (op == 8'h88) mode = 3;
    end else st = 0;
  end
  // ============================================================
  // Read data; a released bus shows the inverse, never a held value
  always @* begin
    rv = ~addr[15:0];
    if (mode == 1) rv = addr[0] ? PART_ID : MAKER_ID;
    if (mode == 3) rv = addr[4] ? uid[addr[2:0]] : {13'h0, addr[2:0]};
    if (mode == 3 && addr[7:0] == 8'hFF) rv = {12'h0, !lk, 3'h0};
  end
  always @(posedge clk) if (!flash_enable_n && !oe_n) last <= rv;
  assign dq_in = (!flash_enable_n && !oe_n) ? rv : ~last;
endmodule

// ---- verif/fcs_host_tb_top.sv ----
// Self-checking bench of the flash command sequencer host
`timescale 1ns/10ps
module fcs_host_tb_top import fcs_pkg::*; ;
  localparam logic [15:0] ID_M = 16'h00C3;
  localparam logic [15:0] ID_P = 16'h5A21;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic cmd_valid = 1'b0;
  fcs_cmd_type cmd = FCS_CMD_READ;
  logic [19:0] cmd_addr = 20'h0;
  logic [15:0] cmd_data = 16'h0;
  logic byte_mode = 1'b0;
  logic cmd_ready, done, refused, flash_enable_n, psram_enable_low_n, psram_enable_high;
  logic oe_n, we_n, byte_word_select, addr_m1, dq_oe, got_ref;
  logic [15:0] rd_data, dq_in, dq_out;
  logic [19:0] addr;
  int miscompares = 0;
  int n_checks = 0;
  int cyc = 0;
  int b0 = 0;
  fcs_host uut(.clk, .rst_b, .cmd_valid, .cmd_ready, .cmd, .cmd_addr, .cmd_data, .byte_mode,
    .done, .refused, .rd_data, .flash_enable_n, .psram_enable_low_n, .psram_enable_high,
    .oe_n, .we_n, .byte_word_select, .addr, .addr_m1, .dq_in, .dq_out, .dq_oe);
  fcs_dev_model #(.MAKER_ID(ID_M), .PART_ID(ID_P)) dev(.clk, .flash_enable_n, .oe_n,
    .we_n, .addr, .dq_out, .dq_oe, .dq_in);
  always #10 clk = ~clk;
  // Each command is a few tens of cycles at most
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      miscompares++;
      test_done();
    end
  end
  task automatic test_done;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [19:0] e, input logic [19:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask
  // ============================================================
  // Bus helpers
  task automatic run(input fcs_cmd_type c, input logic [19:0] a, input logic [15:0] d,
                     input logic b);
    int k;
    @(posedge clk);
    #2;
    b0 = dev.n;
    cmd = c;
    cmd_addr = a;
    cmd_data = d;
    byte_mode = b;
    cmd_valid = 1'b1;
    k = 0;
    while (cmd_ready !== 1'b1) begin
      @(posedge clk);
      #2;
    end
    @(posedge clk);
    #2;
    cmd_valid = 1'b0;
    while (done !== 1'b1 && refused !== 1'b1 && k < 400) begin
      @(posedge clk);
      #2;
      k++;
    end
    got_ref = refused;
    chk("command end", 20'h1, {19'h0, k < 400});
  endtask
  task automatic u(input int i, input logic [10:0] a, input logic [7:0] d);
    chk("cmd addr", {9'h0, a}, {9'h0, dev.la[b0+i][10:0]});
    chk("cmd data", {12'h0, d}, {12'h0, dev.ld[b0+i][7:0]});
  endtask
  task automatic s3(input logic [7:0] op, input int len);
    chk("write count", 20'(len), 20'(dev.n - b0));
    u(0, 11'h555, 8'hAA);
    u(1, 11'h2AA, 8'h55);
    u(2, 11'h555, op);
  endtask
  task automatic rd(input logic [19:0] a, input logic b, input logic [15:0] e);
    run(FCS_CMD_READ, a, 16'h0, b);
    chk("read", {4'h0, e}, {4'h0, rd_data});
  endtask
  // ============================================================
  // Scenarios
  task automatic t_prog;
    run(FCS_CMD_PROGRAM, 20'hABCDE, 16'h1234, 1'b0);
    s3(8'hA0, 4);
    chk("prog addr", 20'hABCDE, dev.la[b0+3]);
    chk("prog data", 20'h01234, {4'h0, dev.ld[b0+3]});
  endtask
  task automatic t_erase;
    fcs_cmd_type c [3] = '{FCS_CMD_SECTOR_ERASE, FCS_CMD_BLOCK_ERASE, FCS_CMD_CHIP_ERASE};
    logic [19:0] ea [3] = '{20'hFE800, 20'hF8000, 20'h00555};
    logic [7:0] ed [3] = '{8'h30, 8'h50, 8'h10};
    for (int i = 0; i < 3; i++) begin
      run(c[i], 20'hFEDCB, 16'h0, 1'b0);
      s3(8'h80, 6);
      u(3, 11'h555, 8'hAA);
      u(4, 11'h2AA, 8'h55);
      u(5, ea[i][10:0], ed[i]);
      if (i < 2) chk("erase addr", ea[i], dev.la[b0+5]);
    end
  endtask
  task automatic t_single;
    fcs_cmd_type c [3] = '{FCS_CMD_SUSPEND, FCS_CMD_RESUME, FCS_CMD_EXIT_SHORT};
    logic [7:0] ed [3] = '{8'hB0, 8'h30, 8'hF0};
    for (int i = 0; i < 3; i++) begin
      run(c[i], 20'h13579, 16'h0, 1'b0);
      chk("write count", 20'h1, 20'(dev.n - b0));
      chk("any addr", 20'h13579, dev.la[b0]);
      u(0, 11'h579, ed[i]);
    end
  endtask
  task automatic t_ident;
    run(FCS_CMD_ID_ENTRY, 20'hFFFFF, 16'h0, 1'b0);
    s3(8'h90, 3);
    chk("bank bits", 20'h0, {18'h0, dev.la[b0+2][19:18]});
    rd(20'h0, 1'b0, ID_M);
    rd(20'h1, 1'b0, ID_P);
    run(FCS_CMD_EXIT_LONG, 20'h0, 16'h0, 1'b0);
    s3(8'hF0, 3);
    rd(20'h0, 1'b0, 16'hFFFF);
    run(FCS_CMD_QUERY_ENTRY, 20'hFFFFF, 16'h0, 1'b0);
    s3(8'h98, 3);
    chk("bank bits", 20'h0, {18'h0, dev.la[b0+2][19:18]});
  endtask
  task automatic t_sec;
    run(FCS_CMD_SEC_QUERY, 20'h0, 16'h0, 1'b0);
    s3(8'h88, 3);
    rd(20'h000FF, 1'b0, 16'h0008);
    rd(20'h00002, 1'b0, 16'h0002);
    run(FCS_CMD_UID_PROGRAM, 20'h00003, 16'h00F0, 1'b0);
    s3(8'hA5, 4);
    chk("uid addr", 20'h00013, dev.la[b0+3]);
    run(FCS_CMD_UID_PROGRAM, 20'h00003, 16'hFF0F, 1'b0);
    rd(20'h00013, 1'b0, 16'h0000);
    run(FCS_CMD_UID_LOCK, 20'h12345, 16'h1111, 1'b1);
    chk("refused", 20'h1, {19'h0, got_ref});
    chk("write count", 20'h0, 20'(dev.n - b0));
    run(FCS_CMD_UID_LOCK, 20'h12345, 16'h1111, 1'b0);
    s3(8'h85, 4);
    chk("lock word", 20'h0, {4'h0, dev.ld[b0+3]});
    rd(20'h000FF, 1'b0, 16'h0000);
    run(FCS_CMD_EXIT_SHORT, 20'h0, 16'h0, 1'b0);
  endtask
  task automatic t_byte;
    run(FCS_CMD_PROGRAM, 20'hFFFFF, 16'hA55A, 1'b1);
    chk("byte select", 20'h0, {19'h0, byte_word_select});
    s3(8'hA0, 4);
    chk("byte addr", 20'h00FFF, dev.la[b0+3]);
    rd(20'h0, 1'b1, 16'h00FF);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    #2;
    rst_b = 1'b1;
    t_prog();
    t_erase();
    t_single();
    t_ident();
    t_sec();
    t_byte();
    test_done();
  end
endmodule
